// file: rtl/uec_command_port.sv
`timescale 1ns/1ps
// Summary of operation
// - clock-on falls 2 ms after suspend detect
// - power-down stops oscillator while clock-on is low
// - clock-on rise restarts oscillator, 2048-cycle count
// - count end raises irq one line
// - command byte then optional data cycles
// - ready high when previous action completed
// - per-endpoint flags, interrupt is their OR with the bus-reset flag
// - D0h writes/reads address and enable
// - function powers up disabled
// - D8h writes/reads non-default endpoint enable
// - bus reset clears endpoint enable
// - 00h+index selects endpoint, optional status read
// - 40h+index reads or sets endpoint status
// - F5h frame number, F3h mode write
// - F4h reads interrupt register, clears bus-reset interrupt
// - F0h reads buffer, pointer increments, ten max
module uec_command_port import uec_pkg::*; #(
   parameter int SUSPEND_DELAY = SUSPEND_CYCLES
) (
   input  wire logic                clock_in,
   input  wire logic                rst_b_in,
   input  wire logic [1:0]          addr_in,
   input  wire logic [7:0]          wdata_in,
   input  wire logic                wr_in,
   input  wire logic                rd_in,
   output logic      [7:0]          rdata_out,
   input  wire logic                bus_reset_in,
   input  wire logic                suspend_detect_in,
   input  wire logic                powerdown_in,
   input  wire logic                irq_source_select_in,
   input  wire logic [EP_COUNT-1:0] ep_event_in,
   input  wire logic [7:0]          ep_event_status_in,
   input  wire logic [10:0]         frame_number_in,
   output logic [$clog2(EP_COUNT)-1:0] ep_select_out,
   output logic [3:0]               buf_ptr_out,
   input  wire logic [7:0]          buf_byte_in,
   input  wire logic [EP_COUNT-1:0] ep_full_in,
   output logic [7:0]               address_enable_out,
   output logic                     ep_enable_out,
   output logic [7:0]               mode_out,
   output logic [EP_COUNT-1:0]      ep_stall_out,
   output logic                     engine_ready_out,
   output logic                     engine_irq_out,
   output logic                     suspend_detect_out,
   output logic                     clock_on_out,
   output logic                     osc_enable_out,
   output logic                     cpu_ext_irq_one_n_out
);
   localparam int EPW = $clog2(EP_COUNT);
   // only the suspend line needs a third stage, for its edge detector
   logic [1:0] bus_reset_sync, pd_sync;
   logic [2:0] susp_sync;
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bus_reset_sync <= 2'h0;
         susp_sync      <= 3'h0;
         pd_sync        <= 2'h0;
      end else begin
         bus_reset_sync <= {bus_reset_sync[0], bus_reset_in};
         susp_sync      <= {susp_sync[1:0], suspend_detect_in};
         pd_sync        <= {pd_sync[0], powerdown_in};
      end
   end
   logic bus_reset, susp_lvl, susp_rise, pd_lvl;
   assign bus_reset = bus_reset_sync[1];
   assign susp_lvl  = susp_sync[1];
   assign susp_rise = susp_sync[1] & ~susp_sync[2];
   assign pd_lvl    = pd_sync[1];

   // command decoding
   uec_phase_t       phase, next_phase;
   logic [7:0]       cmd, next_cmd;
   logic [7:0]       addr_en, next_addr_en;
   logic             ep_en, next_ep_en;
   logic [7:0]       mode, next_mode;
   logic [EPW-1:0]   ep_sel, next_ep_sel;
   logic [3:0]       ptr, next_ptr;
   logic             frame_hi, next_frame_hi;
   logic [EP_COUNT-1:0] flags, next_flags, stall, next_stall;
   logic             reset_irq, next_reset_irq;
   logic [7:0]       ep_status [EP_COUNT];
   logic [7:0]       next_ep_status [EP_COUNT];
   logic [7:0]       rdata, next_rdata;
   logic             is_rd, is_wr, ep_cmd_sel, ep_cmd_stat;
   logic [EPW-1:0]   cmd_ep;

   assign is_wr       = wr_in && addr_in == OFF_DATA;
   assign is_rd       = rd_in && addr_in == OFF_DATA;
   assign cmd_ep      = cmd[EPW-1:0];
   assign ep_cmd_sel  = cmd[7:6] == 2'b00 && 32'(cmd[5:0]) < EP_COUNT;
   assign ep_cmd_stat = cmd[7:6] == 2'b01 && 32'(cmd[5:0]) < EP_COUNT;

   always_comb begin
      next_phase     = phase;
      next_cmd       = cmd;
      next_addr_en   = addr_en;
      next_ep_en     = ep_en;
      next_mode      = mode;
      next_ep_sel    = ep_sel;
      next_ptr       = ptr;
      next_frame_hi  = frame_hi;
      next_flags     = flags & ~ep_event_in;
      next_stall     = stall;
      next_reset_irq = reset_irq;
      next_rdata     = 8'h00;
      if (wr_in && addr_in == OFF_CMD) begin
         next_cmd      = wdata_in;
         next_phase    = UEC_HAVE_CMD;
         next_frame_hi = 1'b0;
         if (wdata_in[7:6] == 2'b00 && 32'(wdata_in[5:0]) < EP_COUNT) begin
            next_ep_sel = wdata_in[EPW-1:0];
            next_ptr    = 4'h0;
         end
      end else if (is_wr && phase != UEC_IDLE) begin
         next_phase = UEC_IN_DATA;
         if (cmd == CMD_ADDR_EN) begin
            next_addr_en = wdata_in;
         end else if (cmd == CMD_EP_EN) begin
            next_ep_en = wdata_in[0];
         end else if (cmd == CMD_SET_MODE) begin
            next_mode = wdata_in;
         end else if (ep_cmd_stat) begin
            next_stall[cmd_ep] = wdata_in[0];
         end
      end else if (is_rd && phase != UEC_IDLE) begin
         next_phase = UEC_IN_DATA;
         if (cmd == CMD_ADDR_EN) begin
            next_rdata = addr_en;
         end else if (cmd == CMD_EP_EN) begin
            next_rdata = {7'h00, ep_en};
         end else if (cmd == CMD_READ_IRQ) begin
            next_rdata     = 8'(flags);
            next_reset_irq = 1'b0;
         end else if (cmd == CMD_FRAME) begin
            next_rdata    = frame_hi ? {5'h00, frame_number_in[10:8]} : frame_number_in[7:0];
            next_frame_hi = 1'b1;
         end else if (cmd == CMD_READ_BUF) begin
            next_rdata = buf_byte_in;
            if (32'(ptr) < BUF_BYTES) begin
               next_ptr = ptr + 4'h1;
            end
         end else if (ep_cmd_sel) begin
            next_rdata = {7'h00, ep_full_in[cmd_ep]};
         end else if (ep_cmd_stat) begin
            next_rdata         = ep_status[cmd_ep];
            next_flags[cmd_ep] = 1'b0;
         end
      end else if (rd_in && addr_in == OFF_STATUS) begin
         next_rdata = {6'h00, engine_irq_out, engine_ready_out};
      end
      next_flags = next_flags | ep_event_in;
      if (bus_reset) begin
         next_ep_en        = 1'b0;
         next_addr_en[ADDR_EN_BIT] = 1'b0;
         next_reset_irq    = 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase     <= UEC_IDLE;
         cmd       <= 8'h00;
         addr_en   <= ADDR_EN_RESET;
         ep_en     <= 1'b0;
         mode      <= MODE_RESET;
         ep_sel    <= '0;
         ptr       <= 4'h0;
         frame_hi  <= 1'b0;
         flags     <= '0;
         stall     <= '0;
         reset_irq <= 1'b0;
         rdata     <= 8'h00;
      end else begin
         phase     <= next_phase;
         cmd       <= next_cmd;
         addr_en   <= next_addr_en;
         ep_en     <= next_ep_en;
         mode      <= next_mode;
         ep_sel    <= next_ep_sel;
         ptr       <= next_ptr;
         frame_hi  <= next_frame_hi;
         flags     <= next_flags;
         stall     <= next_stall;
         reset_irq <= next_reset_irq;
         rdata     <= next_rdata;
      end
   end

   // last-transaction status per endpoint, captured on each event
   always_comb begin
      next_ep_status = ep_status;
      for (int i = 0; i < EP_COUNT; i++) begin
         if (ep_event_in[i]) begin
            next_ep_status[i] = ep_event_status_in;
         end
      end
   end

   // cleared at reset so a status read before any event is not unknown
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ep_status <= '{default: 8'h00};
      end else begin
         ep_status <= next_ep_status;
      end
   end

   // every action completes in one cycle, so ready never drops
   assign engine_ready_out   = 1'b1;
   assign engine_irq_out     = (|flags) | reset_irq;
   assign rdata_out          = rdata;
   assign address_enable_out = addr_en;
   assign ep_enable_out      = ep_en;
   assign mode_out           = mode;
   assign ep_stall_out       = stall;
   assign ep_select_out      = ep_sel;
   assign buf_ptr_out        = ptr;
   assign suspend_detect_out = susp_lvl;

   // suspend and wake sequencing
   uec_pwr_t pwr, next_pwr;
   logic     clk_on, next_clk_on, wake_edge, next_wake_edge;
   logic     susp_done, stable_done;

   uec_counter #(.LIMIT(SUSPEND_DELAY)) u_susp_cnt (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .run_in   (pwr == UEC_SUSP_WAIT),
      .done_out (susp_done)
   );
   uec_counter #(.LIMIT(STABLE_CYCLES)) u_stable_cnt (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .run_in   (pwr == UEC_STABILISE),
      .done_out (stable_done)
   );

   always_comb begin
      next_pwr       = pwr;
      next_clk_on    = clk_on;
      next_wake_edge = wake_edge;
      case (pwr)
         UEC_AWAKE: begin
            if (susp_rise) begin
               next_pwr       = UEC_SUSP_WAIT;
               next_wake_edge = 1'b0;
            end
         end
         UEC_SUSP_WAIT: begin
            if (!susp_lvl) begin
               next_pwr = UEC_AWAKE;
            end else if (susp_done) begin
               next_clk_on = 1'b0;
               next_pwr    = UEC_ASLEEP;
            end
         end
         UEC_ASLEEP: begin
            if (!susp_lvl) begin
               next_clk_on = 1'b1;
               next_pwr    = UEC_STABILISE;
            end
         end
         default: begin
            if (stable_done) begin
               next_wake_edge = 1'b1;
               next_pwr       = UEC_AWAKE;
            end
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pwr       <= UEC_AWAKE;
         clk_on    <= 1'b1;
         wake_edge <= 1'b1;
      end else begin
         pwr       <= next_pwr;
         clk_on    <= next_clk_on;
         wake_edge <= next_wake_edge;
      end
   end

   assign clock_on_out = clk_on;
   // oscillator stops in power-down while clock-on is low
   assign osc_enable_out = ~(pd_lvl & ~clk_on);
   // irq one idles high; select picks restart circuit or engine interrupt
   assign cpu_ext_irq_one_n_out = irq_source_select_in ? wake_edge : ~engine_irq_out;

   a_susp_to_clkon: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      $fell(clk_on) |-> $past(pwr) == UEC_SUSP_WAIT && $past(susp_lvl))
      else $error("clock-on fell outside suspend wait");
   a_wake_after_count: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      $rose(wake_edge) |-> $past(stable_done))
      else $error("wake edge before stabilisation end");
   a_irq_is_or: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (flags != '0) |-> engine_irq_out)
      else $error("interrupt low with flag set");
   a_event_sets_flag: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      ep_event_in[0] |=> flags[0])
      else $error("endpoint event lost");
   a_bus_reset_ep: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      bus_reset |=> !ep_en)
      else $error("endpoint enable survived bus reset");
   a_rise_restarts: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      $rose(clk_on) |=> pwr == UEC_STABILISE)
      else $error("no stabilise after clock-on rise");
   a_addr_write: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      is_wr && phase != UEC_IDLE && cmd == CMD_ADDR_EN && !bus_reset
      && !(wr_in && addr_in == OFF_CMD) |=> addr_en == $past(wdata_in))
      else $error("address write not stored");
   a_buf_ptr_cap: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      32'(ptr) <= BUF_BYTES)
      else $error("buffer pointer past end");
endmodule // uec_command_port

// file: rtl/uec_counter.sv
`timescale 1ns/1ps
module uec_counter import uec_pkg::*; #(
   parameter int LIMIT = 16
) (
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   input  wire logic run_in,
   output logic      done_out
);
   logic [31:0] count;
   logic [31:0] next_count;
   always_comb begin
      next_count = 32'h0;
      if (run_in && count != 32'(LIMIT)) begin
         next_count = count + 32'h1;
      end else if (run_in) begin
         next_count = count;
      end
   end
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         count <= 32'h0;
      end else begin
         count <= next_count;
      end
   end
   assign done_out = run_in && (count == 32'(LIMIT));
endmodule // uec_counter

// file: rtl/uec_pkg.sv
package uec_pkg;
   localparam logic [7:0] CMD_ADDR_EN    = 8'hd0;
   localparam logic [7:0] CMD_EP_EN      = 8'hd8;
   localparam logic [7:0] CMD_SET_MODE   = 8'hf3;
   localparam logic [7:0] CMD_READ_IRQ   = 8'hf4;
   localparam logic [7:0] CMD_FRAME      = 8'hf5;
   localparam logic [7:0] CMD_READ_BUF   = 8'hf0;
   localparam logic [7:0] CMD_SELECT_EP  = 8'h00;
   localparam logic [7:0] CMD_EP_STATUS  = 8'h40;
   localparam int         EP_COUNT       = 6;
   localparam int         BUF_BYTES      = 10;
   localparam int         ADDR_EN_BIT    = 7;
   localparam logic [7:0] ADDR_EN_RESET  = 8'h00;
   localparam logic [7:0] MODE_RESET     = 8'h00;
   localparam int         CLK_MHZ        = 250;
   localparam int         SUSPEND_US     = 2000;
   localparam int         SUSPEND_CYCLES = SUSPEND_US * CLK_MHZ;
   localparam int         STABLE_CYCLES  = 2048;
   localparam logic [1:0] OFF_CMD        = 2'h0;
   localparam logic [1:0] OFF_DATA       = 2'h1;
   localparam logic [1:0] OFF_STATUS     = 2'h2;
   typedef enum logic [1:0] {UEC_IDLE, UEC_HAVE_CMD, UEC_IN_DATA} uec_phase_t;
   typedef enum logic [1:0] {UEC_AWAKE, UEC_SUSP_WAIT, UEC_ASLEEP, UEC_STABILISE} uec_pwr_t;
endpackage

// file: sim/tb_usb_engine_command_port.sv
`timescale 1ns/1ps
module tb_usb_engine_command_port import uec_pkg::*;;
   localparam int DLY = 20;
   logic                clock_in = 1'b0;
   logic                rst_b_in = 1'b0;
   logic [1:0]          addr_in = 2'h0;
   logic [7:0]          wdata_in = 8'h00;
   logic                wr_in = 1'b0;
   logic                rd_in = 1'b0;
   logic                bus_reset_in = 1'b0;
   logic                susp_in = 1'b0;
   logic                pd_in = 1'b0;
   logic                sel_in = 1'b0;
   logic [EP_COUNT-1:0] ev_in = '0;
   logic [7:0]          ev_st_in = 8'h00;
   logic [10:0]         frame_in = 11'h5a3;
   logic [7:0]          buf_byte, rdata_out, addr_en, mode;
   logic [EP_COUNT-1:0] full, stall;
   logic [2:0]          ep_sel;
   logic [3:0]          ptr;
   logic                ep_en, rdy, irq, susp_out, clk_on, osc, irq1_n;
   int                  bad_count = 0;
   int                  n_checks = 0;
   logic [7:0]          d;
   always #2 clock_in = ~clock_in;
   uec_buf_model buf_u (.ptr_in(ptr), .byte_out(buf_byte), .full_out(full));
   uec_command_port #(.SUSPEND_DELAY(DLY)) dut_u (
      .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .bus_reset_in(bus_reset_in),
      .suspend_detect_in(susp_in), .powerdown_in(pd_in), .irq_source_select_in(sel_in),
      .ep_event_in(ev_in), .ep_event_status_in(ev_st_in), .frame_number_in(frame_in),
      .ep_select_out(ep_sel), .buf_ptr_out(ptr), .buf_byte_in(buf_byte), .ep_full_in(full),
      .address_enable_out(addr_en), .ep_enable_out(ep_en), .mode_out(mode),
      .ep_stall_out(stall), .engine_ready_out(rdy), .engine_irq_out(irq),
      .suspend_detect_out(susp_out), .clock_on_out(clk_on), .osc_enable_out(osc),
      .cpu_ext_irq_one_n_out(irq1_n));
   task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
      @(posedge clock_in);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic t_reset_and_init;
      chk("addr_en", addr_en, 8'h00);
      chk("ep_en", ep_en, 1'b0);
      chk("clk_on", clk_on, 1'b1);
      chk("rdy", rdy, 1'b1);
      wr(2'h1, 8'hff);
      chk("addr_en idle", addr_en, 8'h00);
      rd(2'h2, d);
      chk("ready", d[0], 1'b1);
      wr(2'h0, CMD_ADDR_EN);
      wr(2'h1, 8'h85);
      chk("addr_en", addr_en, 8'h85);
      rd(2'h1, d);
      chk("addr_en rd", d, 8'h85);
      wr(2'h0, CMD_EP_EN);
      wr(2'h1, 8'h01);
      rd(2'h1, d);
      chk("ep_en rd", d, 8'h01);
      wr(2'h0, CMD_SET_MODE);
      wr(2'h1, 8'h5c);
      chk("mode", mode, 8'h5c);
      wr(2'h0, CMD_FRAME);
      rd(2'h1, d);
      chk("frame lo", d, 8'ha3);
      rd(2'h1, d);
      chk("frame hi", d, 8'h05);
   endtask
   task automatic t_events;
      ev_in <= 6'h08;
      ev_st_in <= 8'h21;
      @(posedge clock_in);
      ev_in <= 6'h00;
      wait_n(2);
      chk("irq", irq, 1'b1);
      chk("irq1_n", irq1_n, 1'b0);
      wr(2'h0, CMD_READ_IRQ);
      rd(2'h1, d);
      chk("irq reg", d, 8'h08);
      wr(2'h0, CMD_EP_STATUS + 8'h03);
      rd(2'h1, d);
      chk("ep status", d, 8'h21);
      wait_n(1);
      chk("irq clear", irq, 1'b0);
      wr(2'h0, CMD_EP_STATUS + 8'h02);
      wr(2'h1, 8'h01);
      chk("stall", stall, 6'h04);
   endtask
   task automatic t_buffer;
      wr(2'h0, CMD_SELECT_EP + 8'h02);
      chk("ep_sel", ep_sel, 3'h2);
      chk("ptr", ptr, 4'h0);
      rd(2'h1, d);
      chk("full", d[0], 1'b1);
      wr(2'h0, CMD_READ_BUF);
      for (int i = 0; i < 3; i++) begin
         rd(2'h1, d);
         chk("buf byte", d, 8'ha0 + 8'(i));
      end
      chk("ptr", ptr, 4'h3);
   endtask
   task automatic t_bus_reset;
      bus_reset_in <= 1'b1;
      wait_n(4);
      bus_reset_in <= 1'b0;
      wait_n(4);
      chk("ep_en", ep_en, 1'b0);
      chk("addr_en", addr_en, 8'h05);
      chk("irq", irq, 1'b1);
      wr(2'h0, CMD_READ_IRQ);
      rd(2'h1, d);
      chk("irq reg", d, 8'h00);
      chk("irq clear", irq, 1'b0);
   endtask
   task automatic t_suspend;
      // wake path is taken by the restart circuit, as firmware would set up
      sel_in <= 1'b1;
      susp_in <= 1'b1;
      wait_n(10);
      chk("susp_out", susp_out, 1'b1);
      chk("clk_on early", clk_on, 1'b1);
      wait_n(DLY);
      chk("clk_on", clk_on, 1'b0);
      // analog modules and general purpose pins live outside this block
      // firmware acts on clock-on falling at its suspend input
      pd_in <= 1'b1;
      wait_n(4);
      // oscillator power follows power-down without firmware help
      chk("osc", osc, 1'b0);
      susp_in <= 1'b0;
      wait_n(6);
      chk("clk_on", clk_on, 1'b1);
      chk("osc", osc, 1'b1);
      // clock-on rose three edges ago; wake comes one edge after the full count
      wait_n(STABLE_CYCLES - 4);
      chk("wake early", irq1_n, 1'b0);
      wait_n(3);
      chk("wake", irq1_n, 1'b1);
      pd_in <= 1'b0;
      sel_in <= 1'b0;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      wait_n(3);
      rst_b_in <= 1'b1;
      @(posedge clock_in);
      t_reset_and_init();
      t_events();
      t_buffer();
      t_bus_reset();
      t_suspend();
      conclude();
   end
   // everything above needs about 2200 cycles
   initial begin
      wait_n(20000);
      bad_count++;
      conclude();
   end
endmodule // tb_usb_engine_command_port

// file: sim/uec_buf_model.sv
`timescale 1ns/1ps
// endpoint buffer side: answers combinationally at the pointer it is shown
module uec_buf_model import uec_pkg::*; (
   input  wire logic [3:0]          ptr_in,
   output logic      [7:0]          byte_out,
   output logic      [EP_COUNT-1:0] full_out
);
   assign byte_out = 8'ha0 + {4'h0, ptr_in};
   // only endpoint 2 holds a packet, so a wrong select reads as empty
   assign full_out = 6'h04;
endmodule // uec_buf_model
